/* verilog/temp_sensor_pkg.sv */
// Shared constants for the temperature sensor conversion and register block
package temp_sensor_pkg;

  // Register pointer values
  localparam logic [7:0] PTR_RESULT = 8'h00;
  localparam logic [7:0] PTR_CONFIG = 8'h01;
  localparam logic [7:0] PTR_LOWER = 8'h02;
  localparam logic [7:0] PTR_UPPER = 8'h03;
  localparam logic [7:0] PTR_TRIGGER = 8'h04;

  // Reset values
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [15:0] CONFIG_RESET = 16'h00c0;
  localparam logic [15:0] LOWER_RESET = 16'h4b00;
  localparam logic [15:0] UPPER_RESET = 16'h5000;

  // Field layout of the configuration register
  localparam int CFG_SINGLE_SHOT_BIT = 13;
  localparam int CFG_FQ_HI = 12;
  localparam int CFG_FQ_LO = 11;
  localparam int CFG_SENSE_BIT = 10;
  localparam int CFG_TM_BIT = 9;
  localparam int CFG_SHUTDOWN_BIT = 8;
  // Writable bits, everything else is read-only
  localparam logic [15:0] CFG_WRITE_MASK = 16'h3f00;
  // Read-only bits take their reset pattern
  localparam logic [15:0] CFG_FIXED_BITS = 16'h00c0;

  // Left-justified 12-bit data occupies bits 15..4
  localparam int DATA_MSB = 15;
  localparam int DATA_LSB = 4;
  localparam int DATA_W = 12;
  localparam logic [3:0] PAD_ZERO = 4'h0;

  // Timing in its own units and the clock rate
  localparam int CLK_HZ = 50000000;
  localparam int CONV_TIME_MS = 26;
  localparam int WAIT_TIME_MS = 54;
  localparam int CONV_CYCLES = CLK_HZ / 1000 * CONV_TIME_MS;
  localparam int WAIT_CYCLES = CLK_HZ / 1000 * WAIT_TIME_MS;

  // Fault queue depth codes to consecutive-fault counts
  localparam logic [2:0] FQ_DEPTH_0 = 3'h1;
  localparam logic [2:0] FQ_DEPTH_1 = 3'h2;
  localparam logic [2:0] FQ_DEPTH_2 = 3'h4;
  localparam logic [2:0] FQ_DEPTH_3 = 3'h6;

  // Depth lookup
  function automatic logic [2:0] fault_depth(input logic [1:0] code);
    case (code)
      2'h0: fault_depth = FQ_DEPTH_0;
      2'h1: fault_depth = FQ_DEPTH_1;
      2'h2: fault_depth = FQ_DEPTH_2;
      default: fault_depth = FQ_DEPTH_3;
    endcase
  endfunction

  // Conversion sequencer states
  typedef enum logic [1:0] {
    ST_CONVERT,
    ST_WAIT,
    ST_IDLE
  } conv_state_e;

endpackage

/* verilog/alarm_if.sv */
// Carrier between the register core and the alarm controller
`timescale 1ns/1ps
interface alarm_if;
  logic result_valid; // One-cycle pulse, new result stored
  logic signed [11:0] result; // Latest result
  logic signed [11:0] upper; // Upper limit
  logic signed [11:0] lower; // Lower limit
  logic [1:0] fault_queue_count; // Queue depth code
  logic thermostat_mode_select; // 0 comparator, 1 interrupt
  logic shutdown_control; // Shutdown level
  logic reg_read; // Pulse, any register read
  logic alarm_active; // Alarm state, polarity not applied

  modport ctrl (
    input result_valid,
    input result,
    input upper,
    input lower,
    input fault_queue_count,
    input thermostat_mode_select,
    input shutdown_control,
    input reg_read,
    output alarm_active
  );

  modport core (
    output result_valid,
    output result,
    output upper,
    output lower,
    output fault_queue_count,
    output thermostat_mode_select,
    output shutdown_control,
    output reg_read,
    input alarm_active
  );
endinterface // alarm_if

/* verilog/alarm_ctrl.sv */
// Fault queue and thermostat alarm controller
`timescale 1ns/1ps
module alarm_ctrl
  import temp_sensor_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  alarm_if.ctrl bus
);

  logic [2:0] fault_count; // Consecutive qualifying results
  logic seek_high; // Interrupt mode: armed for the upper limit
  logic alarm; // Alarm state
  logic hit_high; // Result at or above upper limit
  logic hit_low; // Result below lower limit
  logic qualify; // This result counts toward a change
  logic [2:0] depth; // Required consecutive count

  // Signed compare keeps negative temperatures in order
  // signed limit compare
  assign hit_high = bus.result >= bus.upper;
  assign hit_low = bus.result < bus.lower;
  assign depth = fault_depth(bus.fault_queue_count);

  // Comparator looks at the state, interrupt mode at the arming flag
  always_comb
  begin
    if (bus.thermostat_mode_select)
      qualify = seek_high ? hit_high : hit_low;
    else
      qualify = alarm ? hit_low : hit_high;
  end

  // Consecutive fault counter, cleared by any break in the run
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      fault_count <= 3'h0;
    else if (bus.shutdown_control)
      fault_count <= 3'h0;
    else if (bus.result_valid)
    begin
      if (!qualify || (fault_count + 3'h1 >= depth))
        fault_count <= 3'h0;
      else
        fault_count <= fault_count + 3'h1;
    end
  end

  // Alarm and arming flag; a new event wins over a read clear
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      alarm <= 1'b0;
      seek_high <= 1'b1;
    end
    else if (bus.shutdown_control && bus.thermostat_mode_select)
    begin
      alarm <= 1'b0;
    end
    else if (bus.result_valid && qualify && (fault_count + 3'h1 >= depth))
    begin
      if (bus.thermostat_mode_select)
      begin
        alarm <= 1'b1;
        seek_high <= !seek_high;
      end
      else
      begin
        alarm <= !alarm;
        seek_high <= 1'b1;
      end
    end
    else if (bus.thermostat_mode_select && bus.reg_read)
      alarm <= 1'b0;
    else if (!bus.thermostat_mode_select)
      seek_high <= 1'b1;
  end

  assign bus.alarm_active = alarm;

endmodule // alarm_ctrl

/* verilog/temp_sensor_core.sv */
// Conversion sequencer and pointer register bank of the temperature sensor
//
// How it works
// - Results stored as 12-bit two's complement
// - Result reads zero until first conversion
// - Four low result bits read zero
// - Two-byte reads, host may stop early
// - Result left-justified in bits 15..4
// - Pointer decodes result, config, limits, trigger
// - Lower limit 12 bits, reset 0x4B00
// - Upper limit 12 bits, reset 0x5000
// - Config field positions, other bits read-only
// - Config defaults continuous, 1 fault, low, comparator
// - Shutdown overrides single-shot, else continuous
// - Queue codes mean 1, 2, 4, 6
// - Alarm polarity follows sense level bit
// - Mode bit selects comparator or interrupt
// - Continuous mode overwrites result each conversion
// - Convert 26 ms, wait 54 ms, 80 ms period
// - First conversion starts right after reset
// - Shutdown aborts conversion, interface stays alive
// - Trigger write runs one conversion then idles
// - Trigger ignored while shut down
// - Comparator sets high, clears below lower limit
// - Interrupt alarm cleared by read or shutdown
// - First written byte loads the pointer
// - Register bytes move high byte first
`timescale 1ns/1ps
module temp_sensor_core
  import temp_sensor_pkg::*;
#(
  parameter int CONV_COUNT = CONV_CYCLES, // Cycles per conversion
  parameter int WAIT_COUNT = WAIT_CYCLES // Cycles of powered-down wait
)
(
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_xfer_start,
  input wire logic i_wr_byte_valid,
  input wire logic [7:0] i_wr_byte,
  input wire logic i_rd_byte_req,
  input wire logic [temp_sensor_pkg::DATA_W-1:0] i_adc_code,
  output logic [7:0] o_rd_byte,
  output logic o_rd_byte_valid,
  output logic o_adc_enable,
  output logic o_alarm_output,
  output logic o_alarm_output_oe,
  output logic [1:0] o_conv_state
);

  import temp_sensor_pkg::*;

  // Width of the timing counter, enough for the longer phase
  // Sized from the parameters, so short test counts give a small counter
  localparam int CNT_W = $clog2((CONV_COUNT > WAIT_COUNT ? CONV_COUNT : WAIT_COUNT) + 1);
  localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_COUNT - 1);
  localparam logic [CNT_W-1:0] WAIT_LAST = CNT_W'(WAIT_COUNT - 1);

  // Register bank
  logic [DATA_W-1:0] temperature_result; // Latest result, read-only
  logic [15:0] operating_configuration; // Writable control fields only
  logic [DATA_W-1:0] lower_alarm_limit; // Lower limit data bits
  logic [DATA_W-1:0] upper_alarm_limit; // Upper limit data bits

  // Pointer and byte sequencing
  logic [7:0] pointer; // Last pointer written
  logic [1:0] wr_index; // Byte position in a write
  logic [7:0] wr_high; // High byte held until the low byte lands
  logic rd_index; // 0 high byte next, 1 low byte next
  logic [7:0] rd_low; // Low byte from the snapshot

  // Sequencer
  conv_state_e state; // Conversion state
  conv_state_e next_state; // Following state
  logic [CNT_W-1:0] timer; // Phase timer
  logic conv_done; // Last cycle of a conversion
  logic wait_done; // Last cycle of the wait
  logic trigger_write; // Data byte to the trigger register
  logic reg_read; // First byte of a register read

  // Decoded configuration fields
  logic single_shot_enable;
  logic [1:0] fault_queue_count;
  logic alarm_sense_level;
  logic thermostat_mode_select;
  logic shutdown_control;

  // Register views and write strobes
  logic [15:0] read_word; // Word selected by the pointer
  logic wr_commit; // Low byte completes a 16-bit write
  logic [15:0] wr_word; // Assembled write data

  alarm_if alarm_bus ();

  assign single_shot_enable = operating_configuration[CFG_SINGLE_SHOT_BIT];
  assign fault_queue_count = operating_configuration[CFG_FQ_HI:CFG_FQ_LO];
  assign alarm_sense_level = operating_configuration[CFG_SENSE_BIT];
  assign thermostat_mode_select = operating_configuration[CFG_TM_BIT];
  assign shutdown_control = operating_configuration[CFG_SHUTDOWN_BIT];

  // Byte pairing of a host write
  assign wr_commit = i_wr_byte_valid && (wr_index == 2'h2);
  assign wr_word = {wr_high, i_wr_byte};
  assign trigger_write = i_wr_byte_valid && (wr_index == 2'h1) && (pointer == PTR_TRIGGER)
    && !shutdown_control;
  // Only the first byte of a read counts as a register read
  assign reg_read = i_rd_byte_req && !rd_index;

  // Pointer and write byte position
  // A new transaction always restarts the byte count, so a host that
  // abandons a write halfway leaves no half-built word behind
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      pointer <= PTR_RESULT;
      wr_index <= 2'h0;
      wr_high <= 8'h00;
    end
    else if (i_xfer_start)
      wr_index <= 2'h0;
    else if (i_wr_byte_valid)
    begin
      if (wr_index == 2'h0)
        pointer <= i_wr_byte;
      if (wr_index == 2'h1)
        wr_high <= i_wr_byte;
      // Bytes past the low one are dropped
      if (wr_index != 2'h3)
        wr_index <= wr_index + 2'h1;
    end
  end

  // Configuration register; only control bits are stored
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      operating_configuration <= CONFIG_RESET & CFG_WRITE_MASK;
    else if (wr_commit && pointer == PTR_CONFIG)
      operating_configuration <= wr_word & CFG_WRITE_MASK;
  end

  // Limit registers keep only bits 15..4
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      lower_alarm_limit <= LOWER_RESET[DATA_MSB:DATA_LSB];
      upper_alarm_limit <= UPPER_RESET[DATA_MSB:DATA_LSB];
    end
    else if (wr_commit)
    begin
      if (pointer == PTR_LOWER)
        lower_alarm_limit <= wr_word[DATA_MSB:DATA_LSB];
      if (pointer == PTR_UPPER)
        upper_alarm_limit <= wr_word[DATA_MSB:DATA_LSB];
    end
  end

  // Pointer decode of the read word
  always_comb
  begin
    case (pointer)
      PTR_RESULT: read_word = {temperature_result, PAD_ZERO};
      PTR_CONFIG: read_word = operating_configuration | CFG_FIXED_BITS;
      PTR_LOWER: read_word = {lower_alarm_limit, PAD_ZERO};
      PTR_UPPER: read_word = {upper_alarm_limit, PAD_ZERO};
      // Trigger and unmapped pointers read as zero
      default: read_word = RESULT_RESET;
    endcase
  end

  // Read byte path; the low byte is snapshot with the high one so that
  // a conversion landing between the two bytes cannot tear the word
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      rd_index <= 1'b0;
      rd_low <= 8'h00;
      o_rd_byte <= 8'h00;
      o_rd_byte_valid <= 1'b0;
    end
    else
    begin
      o_rd_byte_valid <= i_rd_byte_req;
      if (i_xfer_start)
        // early stop leaves no state behind
        rd_index <= 1'b0;
      else if (i_rd_byte_req)
      begin
        if (!rd_index)
        begin
          o_rd_byte <= read_word[15:8];
          rd_low <= read_word[7:0];
        end
        else
          o_rd_byte <= rd_low;
        rd_index <= !rd_index;
      end
    end
  end

  // Conversion sequencer next state
  // Shutdown is tested first in convert and wait, and gates trigger_write in idle,
  // so that it always wins over a pending trigger or a phase that is just ending
  always_comb
  begin
    next_state = state;
    case (state)
      ST_CONVERT:
      begin
        if (shutdown_control)
          next_state = ST_IDLE;
        else if (conv_done)
          next_state = single_shot_enable ? ST_IDLE : ST_WAIT;
      end
      ST_WAIT:
      begin
        // shutdown or single shot stop the loop
        if (shutdown_control || single_shot_enable)
          next_state = ST_IDLE;
        else if (wait_done)
          next_state = ST_CONVERT;
      end
      ST_IDLE:
      begin
        if (single_shot_enable && trigger_write)
          next_state = ST_CONVERT;
        else if (!shutdown_control && !single_shot_enable)
          next_state = ST_CONVERT;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  assign conv_done = (state == ST_CONVERT) && (timer == CONV_LAST);
  assign wait_done = (state == ST_WAIT) && (timer == WAIT_LAST);

  // State register; reset lands in a conversion
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      state <= ST_CONVERT;
    else
      state <= next_state;
  end

  // Phase timer restarts on every state change
  // Idle holds the timer still, which saves toggling while powered down
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      timer <= '0;
    else if (next_state != state)
      timer <= '0;
    else if (state != ST_IDLE)
      timer <= timer + CNT_W'(1);
  end

  // Result register, written only by a finished conversion
  // An aborted conversion leaves the previous result untouched
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      temperature_result <= RESULT_RESET[DATA_MSB:DATA_LSB];
    else if (conv_done && !shutdown_control)
      temperature_result <= i_adc_code;
  end

  // Alarm controller hookup
  // The alarm judges the same code that is stored, in the same cycle
  assign alarm_bus.result_valid = conv_done && !shutdown_control;
  assign alarm_bus.result = i_adc_code;
  assign alarm_bus.upper = upper_alarm_limit;
  assign alarm_bus.lower = lower_alarm_limit;
  assign alarm_bus.fault_queue_count = fault_queue_count;
  assign alarm_bus.thermostat_mode_select = thermostat_mode_select;
  assign alarm_bus.shutdown_control = shutdown_control;
  assign alarm_bus.reg_read = reg_read;

  alarm_ctrl u_alarm_ctrl (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .bus(alarm_bus.ctrl)
  );

  // Open-drain alarm pin; the wire is pulled low whenever the wanted
  // level is zero, so polarity only decides when the enable is on
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      o_alarm_output_oe <= 1'b0;
    else
      o_alarm_output_oe <= (alarm_bus.alarm_active == alarm_sense_level) ? 1'b0 : 1'b1;
  end

  assign o_alarm_output = 1'b0;

  // Analog front end only powered while converting
  // power down outside conversion
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      o_adc_enable <= 1'b0;
    else
      o_adc_enable <= (next_state == ST_CONVERT);
  end

  // Sequencer state for observation
  assign o_conv_state = state;

endmodule // temp_sensor_core

/* verif/temp_sensor_checker.sv */
// Port assertions for the sensor core
`timescale 1ns/1ps
module temp_sensor_checker
  import temp_sensor_pkg::*;
#(
  parameter int CONV_COUNT = 20, // Convert cycles
  parameter int WAIT_COUNT = 40 // Wait cycles
)
(
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_wr_byte_valid,
  input wire logic i_rd_byte_req,
  input wire logic [7:0] o_rd_byte,
  input wire logic o_rd_byte_valid,
  input wire logic o_adc_enable,
  input wire logic o_alarm_output,
  input wire logic o_alarm_output_oe,
  input wire logic [1:0] o_conv_state
);
  logic [1:0] prev_state; // State at last edge
  int run; // Edges in current state
  logic armed; // Runs whole once a wait seen
  logic [3:0] recent; // Recent pin-moving causes
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rstn);
  // The run after reset is partial, so armed gates it
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      prev_state <= ST_CONVERT;
      run <= 0;
      armed <= 1'b0;
      recent <= 4'h0;
    end
    else
    begin
      prev_state <= o_conv_state;
      run <= (o_conv_state == prev_state) ? run + 1 : 1;
      armed <= armed | (o_conv_state == ST_WAIT);
      recent <= {recent[2:0], o_adc_enable | i_wr_byte_valid | i_rd_byte_req};
    end
  end
  // Steps of the sequencer
  sequence s_conv_end;
    o_conv_state == ST_CONVERT ##1 o_conv_state == ST_WAIT && armed;
  endsequence
  sequence s_wait_end;
    o_conv_state == ST_WAIT ##1 o_conv_state == ST_CONVERT;
  endsequence
  sequence s_idle_exit;
    o_conv_state == ST_IDLE ##1 o_conv_state == ST_CONVERT;
  endsequence
  a_conv_length: assert property (s_conv_end |-> run == CONV_COUNT)
    else $error("conversion length wrong");
  a_wait_length: assert property (s_wait_end |-> run == WAIT_COUNT)
    else $error("wait length wrong");
  a_adc_tracks: assert property ($past(i_rstn) |-> o_adc_enable == (o_conv_state == ST_CONVERT))
    else $error("converter enable off state");
  a_rd_answer: assert property (i_rd_byte_req |=> o_rd_byte_valid)
    else $error("read byte not answered");
  a_rd_quiet: assert property (!i_rd_byte_req |=> !o_rd_byte_valid && $stable(o_rd_byte))
    else $error("read byte moved unasked");
  a_idle_exit: assert property (s_idle_exit |-> $past(i_wr_byte_valid) || $past(i_wr_byte_valid, 2))
    else $error("conversion from idle without write");
  a_idle_no_wait: assert property (o_conv_state == ST_IDLE |=> o_conv_state != ST_WAIT)
    else $error("idle went to wait");
  a_pin_data_low: assert property (o_alarm_output == 1'b0)
    else $error("alarm data not low");
  a_pin_cause: assert property ($changed(o_alarm_output_oe) |-> |recent)
    else $error("alarm pin moved without cause");
endmodule // temp_sensor_checker

bind temp_sensor_core temp_sensor_checker #(.CONV_COUNT(CONV_COUNT), .WAIT_COUNT(WAIT_COUNT))
  temp_sensor_checker_i (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
  .i_wr_byte_valid(i_wr_byte_valid), .i_rd_byte_req(i_rd_byte_req),
  .o_rd_byte(o_rd_byte), .o_rd_byte_valid(o_rd_byte_valid), .o_adc_enable(o_adc_enable),
  .o_alarm_output(o_alarm_output), .o_alarm_output_oe(o_alarm_output_oe),
  .o_conv_state(o_conv_state));

/* verif/bus_host_model.sv */
// Byte-level bus host at the register port
`timescale 1ns/1ps
module bus_host_model
(
  input wire logic i_sys_clk,
  output logic o_xfer_start,
  output logic o_wr_byte_valid,
  output logic [7:0] o_wr_byte,
  output logic o_rd_byte_req
);
  // Idle from time zero
  initial
  begin
    {o_xfer_start, o_wr_byte_valid, o_rd_byte_req} = 3'h0;
    o_wr_byte = 8'h00;
  end
  // One strobe cycle; released data inverts, never stale
  task automatic step(input logic [2:0] s, input logic [7:0] b);
    @(posedge i_sys_clk);
    #1;
    {o_xfer_start, o_wr_byte_valid, o_rd_byte_req} = s;
    o_wr_byte = b;
    @(posedge i_sys_clk);
    #1;
    {o_xfer_start, o_wr_byte_valid, o_rd_byte_req} = 3'h0;
    o_wr_byte = ~b;
  endtask
  task automatic wr(input logic [7:0] ptr, input logic [15:0] d, input int n);
    step(3'h4, ~o_wr_byte);
    step(3'h2, ptr);
    if (n > 0)
      step(3'h2, d[15:8]);
    if (n > 1)
      step(3'h2, d[7:0]);
  endtask
  task automatic rd(input logic [7:0] ptr, input int n, input logic setp);
    if (setp)
      wr(ptr, 16'h0000, 0);
    step(3'h4, ~o_wr_byte);
    repeat (n)
      step(3'h1, ~o_wr_byte);
  endtask
endmodule // bus_host_model

/* verif/temp_sensor_core_bench.sv */
// Self-checking bench for the sensor core
`timescale 1ns/1ps
module temp_sensor_core_bench;
  import temp_sensor_pkg::*;
  localparam int CONV_N = 20; // Short convert
  localparam int WAIT_N = 40; // Short wait
  logic clk, rstn, xfer_start, wr_valid, rd_req; // Clock, reset, strobes
  logic [7:0] wr_byte, rd_byte; // Byte paths
  logic rd_valid, adc_en, alarm_out, oe; // Outputs
  logic [1:0] state; // Sequencer state
  logic [11:0] code, r; // Converter code, random pick
  logic [7:0] expq[$]; // Expected bytes, oldest first
  int n_mismatch = 0;
  int total_checks = 0;
  int depth[4] = '{1, 2, 4, 6}; // Faults per queue code
  temp_sensor_core #(.CONV_COUNT(CONV_N), .WAIT_COUNT(WAIT_N)) temp_sensor_core_i (
    .i_sys_clk(clk), .i_rstn(rstn), .i_xfer_start(xfer_start), .i_wr_byte_valid(wr_valid),
    .i_wr_byte(wr_byte), .i_rd_byte_req(rd_req), .i_adc_code(code), .o_rd_byte(rd_byte),
    .o_rd_byte_valid(rd_valid), .o_adc_enable(adc_en), .o_alarm_output(alarm_out),
    .o_alarm_output_oe(oe), .o_conv_state(state));
  bus_host_model bus_host_model_i (.i_sys_clk(clk), .o_xfer_start(xfer_start),
    .o_wr_byte_valid(wr_valid), .o_wr_byte(wr_byte), .o_rd_byte_req(rd_req));
  // Free-running clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Compare and count; x matches only x
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Answered bytes against oldest note
  always @(negedge clk)
    if (rd_valid === 1'b1)
      cmp({8'h00, rd_byte}, (expq.size() > 0) ? {8'h00, expq.pop_front()} : 16'hxxxx);
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Bounded wait on converter enable
  task automatic lvl(input logic v);
    int k;
    for (k = 0; k < 200 && adc_en !== v; k++)
      tick(1);
    if (adc_en !== v)
    begin
      n_mismatch++;
      test_done();
    end
  endtask
  task automatic fall();
    lvl(1'b1);
    lvl(1'b0);
  endtask
  task automatic rd_chk(input logic [7:0] p, input logic [15:0] e, input int n, input logic s);
    expq.push_back(e[15:8]);
    if (n > 1)
      expq.push_back(e[7:0]);
    bus_host_model_i.rd(p, n, s);
  endtask
  // Conversions until the pin reaches want
  task automatic alarm_after(input logic want, input int exp_n);
    int n;
    for (n = 1; n < 9; n++)
    begin
      fall();
      tick(4);
      if (oe === want)
        break;
    end
    cmp(16'(n), 16'(exp_n));
  endtask
  task automatic test_done();
    if (expq.size() != 0)
      n_mismatch++;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    rstn = 1'b0;
    code = 12'h000;
    r = 12'($urandom(32'ha30e_af2a));
    tick(3);
    rstn = 1'b1;
    tick(2);
    cmp(16'(adc_en), 16'h0001);
    rd_chk(PTR_RESULT, 16'h0000, 2, 1'b1);
    rd_chk(PTR_CONFIG, 16'h00c0, 2, 1'b1);
    rd_chk(PTR_LOWER, 16'h4b00, 2, 1'b1);
    rd_chk(PTR_UPPER, 16'h5000, 2, 1'b1);
    rd_chk(PTR_TRIGGER, 16'h0000, 2, 1'b1);
    rd_chk(8'h07, 16'h0000, 2, 1'b1);
    $display("test map done");
    for (int i = 0; i < 2; i++)
    begin
      r = 12'($urandom);
      fall();
      code = r;
      fall();
      rd_chk(PTR_RESULT, {r, 4'h0}, 2, 1'b1);
    end
    $display("test continuous done");
    bus_host_model_i.wr(PTR_LOWER, 16'hf00f, 2);
    bus_host_model_i.wr(PTR_UPPER, 16'h020a, 2);
    bus_host_model_i.wr(PTR_RESULT, 16'h1234, 2);
    rd_chk(PTR_LOWER, 16'hf000, 2, 1'b1);
    rd_chk(PTR_UPPER, 16'h0200, 2, 1'b1);
    rd_chk(PTR_UPPER, 16'h0200, 2, 1'b0);
    rd_chk(PTR_RESULT, {r, 4'h0}, 2, 1'b1);
    code = 12'heff;
    fall();
    fall();
    $display("test limits done");
    for (int fq = 0; fq < 4; fq++)
    begin
      bus_host_model_i.wr(PTR_CONFIG, 16'(fq << 11), 2);
      rd_chk(PTR_CONFIG, 16'(fq << 11) | 16'h00c0, 2, 1'b1);
      fall();
      code = 12'h020;
      alarm_after(1'b1, depth[fq]);
      code = 12'heff;
      alarm_after(1'b0, depth[fq]);
    end
    bus_host_model_i.wr(PTR_CONFIG, 16'h0400, 2);
    tick(4);
    cmp(16'(oe), 16'h0001);
    $display("test comparator done");
    bus_host_model_i.wr(PTR_CONFIG, 16'h0200, 2);
    fall();
    code = 12'h020;
    alarm_after(1'b1, 1);
    rd_chk(PTR_RESULT, 16'h0200, 1, 1'b1);
    tick(4);
    cmp(16'(oe), 16'h0000);
    fall();
    tick(4);
    cmp(16'(oe), 16'h0000);
    $display("test interrupt done");
    lvl(1'b1);
    code = 12'h7f0;
    bus_host_model_i.wr(PTR_CONFIG, 16'h0100, 2);
    tick(2);
    cmp({13'h0000, state, adc_en}, {13'h0000, 2'(ST_IDLE), 1'b0});
    bus_host_model_i.wr(PTR_TRIGGER, 16'h0000, 1);
    tick(30);
    cmp(16'(state), 16'(ST_IDLE));
    rd_chk(PTR_RESULT, 16'h0200, 2, 1'b1);
    bus_host_model_i.wr(PTR_CONFIG, 16'h2000, 2);
    tick(4);
    cmp(16'(state), 16'(ST_IDLE));
    r = 12'($urandom);
    code = r;
    bus_host_model_i.wr(PTR_TRIGGER, 16'h0000, 1);
    fall();
    tick(CONV_N);
    cmp(16'(state), 16'(ST_IDLE));
    rd_chk(PTR_RESULT, {r, 4'h0}, 2, 1'b1);
    tick(8);
    $display("test shutdown done");
    test_done();
  end
endmodule // temp_sensor_core_bench
